// file: fwrp_pkg.sv
// Shared constants and carrier types of the four-wire register port.
package fwrp_pkg;

    // ------------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------------
    localparam int         ADDR_W        = 7;
    localparam int         PAGE_W        = 2;
    localparam int         EXT_W         = ADDR_W + PAGE_W;
    localparam int         DATA_W        = 8;
    localparam int         CNT_W         = 5;
    localparam logic [4:0] CMD_ADDR_BITS = 5'h07;
    localparam logic [4:0] CMD_BITS      = 5'h08;
    localparam logic [4:0] FRAME_BITS    = 5'h10;

    // ------------------------------------------------------------------
    // Page-extended address map
    // ------------------------------------------------------------------
    localparam logic [6:0] PAGE_CTRL_ADDR = 7'h00;
    localparam logic [8:0] RANGE_A_LO     = 9'h050;
    localparam logic [8:0] RANGE_A_HI     = 9'h067;
    localparam logic [8:0] RANGE_B_LO     = 9'h0d0;
    localparam logic [8:0] RANGE_B_HI     = 9'h0df;
    localparam logic [8:0] RANGE_C_LO     = 9'h140;
    localparam logic [8:0] RANGE_C_HI     = 9'h14f;
    localparam logic [8:0] CFG_ADDR       = 9'h105;
    localparam logic [8:0] AUX_ADDR       = 9'h106;
    localparam int         A_SIZE         = 24;
    localparam int         B_SIZE         = 16;
    localparam int         C_SIZE         = 16;
    localparam logic [7:0] P4_READ_VALUE  = 8'h00;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         PAGE_LSB       = 0;
    localparam int         RETURN_BIT     = 7;
    localparam int         CFG_LSB        = 0;
    localparam logic [1:0] PAGE_RESET     = 2'h0;
    localparam logic [7:0] AUX_RESET      = 8'h00;

    // Serial port configuration, low nibble of register 0x105.
    typedef struct packed {
        logic dir_pol;
        logic sel_pol;
        logic cpha;
        logic cpol;
    } fwrp_cfg_s;

    localparam fwrp_cfg_s CFG_RESET = 4'h0;

    // One completed frame handed from the link to the system clock.
    typedef struct packed {
        logic             write;
        logic [EXT_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fwrp_frame_s;

    // Register write as applied on the system clock.
    typedef struct packed {
        logic              valid;
        logic [EXT_W-1:0]  addr;
        logic [DATA_W-1:0] data;
    } fwrp_write_s;

endpackage

// file: fwrp_sync.sv
// Two-stage level synchroniser into the system clock.
`timescale 1ns/10ps
`default_nettype none
module fwrp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fwrp_sync_s;

    fwrp_sync_s state;
    fwrp_sync_s next_state;

    // The first stage feeds only the second stage.
    always_comb begin
        next_state    = state;
        next_state.s1 = d;
        next_state.s2 = state.s1;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.s2;
endmodule
`default_nettype wire

// file: fwrp_reg_store.sv
// Byte registers of the device's own address ranges.
`timescale 1ns/10ps
`default_nettype none
module fwrp_reg_store (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Write port, system clock
    input  wire fwrp_pkg::fwrp_write_s wr,
    output logic                     wr_hit,
    // Read port, quasi-static
    input  wire logic [8:0]          rd_addr,
    output logic [7:0]               rd_data,
    output logic                     rd_hit
);
    import fwrp_pkg::*;

    typedef struct packed {
        logic [A_SIZE-1:0][DATA_W-1:0] a;
        logic [B_SIZE-1:0][DATA_W-1:0] b;
        logic [C_SIZE-1:0][DATA_W-1:0] c;
    } fwrp_store_s;

    fwrp_store_s state;
    fwrp_store_s next_state;
    logic        ra;
    logic        rb;
    logic        rc;
    logic [8:0]  wa_off;
    logic [8:0]  wb_off;
    logic [8:0]  wc_off;
    logic [8:0]  ra_off;
    logic [8:0]  rb_off;
    logic [8:0]  rc_off;

    // Range decode.
    always_comb begin
        ra     = rd_addr >= RANGE_A_LO && rd_addr <= RANGE_A_HI;
        rb     = rd_addr >= RANGE_B_LO && rd_addr <= RANGE_B_HI;
        rc     = rd_addr >= RANGE_C_LO && rd_addr <= RANGE_C_HI;
        ra_off = rd_addr - RANGE_A_LO;
        rb_off = rd_addr - RANGE_B_LO;
        rc_off = rd_addr - RANGE_C_LO;
        rd_hit = ra | rb | rc;           // see RULE22
        if (ra) begin
            rd_data = state.a[ra_off[4:0]];
        end else if (rb) begin
            rd_data = state.b[rb_off[3:0]];
        end else if (rc) begin
            rd_data = state.c[rc_off[3:0]];
        end else begin
            rd_data = P4_READ_VALUE;
        end
    end

    // Writes land only inside the writable ranges.
    always_comb begin
        next_state = state;
        wa_off     = wr.addr - RANGE_A_LO;
        wb_off     = wr.addr - RANGE_B_LO;
        wc_off     = wr.addr - RANGE_C_LO;
        wr_hit     = 1'b1;
        if (wr.addr >= RANGE_A_LO && wr.addr <= RANGE_A_HI) begin
            if (wr.valid) next_state.a[wa_off[4:0]] = wr.data;
        end else if (wr.addr >= RANGE_B_LO && wr.addr <= RANGE_B_HI) begin
            if (wr.valid) next_state.b[wb_off[3:0]] = wr.data;
        end else if (wr.addr >= RANGE_C_LO && wr.addr <= RANGE_C_HI) begin
            if (wr.valid) next_state.c[wc_off[3:0]] = wr.data;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// file: fwrp_port.sv
// Four-wire serial register port: link shifter and page/config logic.
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1 - Port has select, host clock, serial in and serial out signals.
// RULE2 - Register map is four pages of up to 128 registers.
// RULE3 - Address zero selects the page; auto return drops back to page 0.
// RULE4 - Page 0, holding 0x50 to 0x6F, is active after reset; the code's page 0 range ends at 0x67.
// RULE5 - Host reads the page control back after a plain page change; the code never drives reads of address zero.
// RULE6 - Foreign registers are write only; reads get no answer, output off.
// RULE7 - Writes to 0x105 and 0x106 configure the serial port.
// RULE8 - Each transfer is one half-duplex 16-bit frame, up to 14 MHz; the bench host clocks at a 6 ns period.
// RULE9 - Frame is an 8-bit command byte then an 8-bit data byte.
// RULE10 - First seven command bits are the address, decoded after bit seven.
// RULE11 - Eighth bit is direction, read through the direction polarity bit.
// RULE12 - On writes the host drives eight data bits after the command.
// RULE13 - On reads the device shifts the register out in eight clocks.
// RULE14 - Address and data travel most significant bit first.
// RULE15 - Select active level comes from the select polarity bit.
// RULE16 - Inactive select resets the port; host releases it between frames.
// RULE17 - Serial output is driven only in the data half of reads.
// RULE18 - Clock polarity sets the idle level of the serial clock.
// RULE19 - Polarity and phase pick the output and sample clock edges.
// RULE20 - Host uses the same clock polarity and phase as the device.
// RULE21 - Host waits one frame before reading back a fresh write.
// RULE22 - Accesses outside the supported ranges are ignored, output off.
// RULE23 - Clock edges beyond the sixteenth in a frame are ignored.
module fwrp_port #(
    parameter fwrp_pkg::fwrp_cfg_s CFG_DEFAULT  = fwrp_pkg::CFG_RESET,
    parameter logic [7:0]          AUX_DEFAULT  = fwrp_pkg::AUX_RESET,
    parameter logic [1:0]          PAGE_DEFAULT = fwrp_pkg::PAGE_RESET
) (
    // System clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Serial pins
    input  wire logic                  select_line,
    input  wire logic                  serial_clock_in,
    input  wire logic                  serial_data_in,
    output logic                       serial_data_out,
    output logic                       serial_data_out_en,
    // Configuration and status
    output fwrp_pkg::fwrp_cfg_s        link_config,
    output logic [1:0]                 active_page,
    output logic                       auto_page_zero_return,
    output logic [7:0]                 aux_config,
    output fwrp_pkg::fwrp_write_s      reg_write
);
    import fwrp_pkg::*;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------

    // Frame progress, cleared whenever select goes inactive.
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [7:0]       shift;
        logic [EXT_W-1:0] ext;
        logic             is_read;
        logic             hit;
    } fwrp_link_s;

    // Hand-over word; survives select so the system side can read it.
    typedef struct packed {
        logic        tog;
        fwrp_frame_s frame;
    } fwrp_xfer_s;

    // Serial output stage on the output edge.
    typedef struct packed {
        logic [7:0] data;
        logic       drive;
    } fwrp_out_s;

    // System-clock state.
    typedef struct packed {
        logic        prev_tog;
        logic [1:0]  page;
        logic        ret;
        fwrp_cfg_s   cfg;
        logic [7:0]  aux;
        fwrp_write_s wr;
    } fwrp_sys_s;

    fwrp_link_s  lk;
    fwrp_link_s  next_lk;
    fwrp_xfer_s  xf;
    fwrp_xfer_s  next_xf;
    fwrp_out_s   so;
    fwrp_out_s   next_so;
    fwrp_sys_s   sys;
    fwrp_sys_s   next_sys;

    logic        sel_active;
    logic        link_rst;
    logic        sample_clk;
    logic        tog_sync;
    logic        frame_event;
    logic        page_ctrl_hit;
    fwrp_write_s store_wr;
    logic        store_wr_hit;
    logic [7:0]  rd_data;
    logic        rd_hit;

    // ------------------------------------------------------------------
    // Link clock and link reset
    // ------------------------------------------------------------------

    // Select is active when its level equals the polarity bit; an idle
    // select holds the link side, except the hand-over word, in reset between frames.
    assign sel_active = select_line ~^ sys.cfg.sel_pol;   // see RULE15
    assign link_rst   = rst | ~sel_active;                 // see RULE16

    // Sampling always happens on the rising edge of this clock. Polarity
    // and phase only flip the clock, and since they change between frames
    // the flip cannot cut a pulse short in the middle of a transfer.
    assign sample_clk = serial_clock_in ^ (sys.cfg.cpol ^ sys.cfg.cpha);
    // see RULE18, see RULE19, see RULE1

    // ------------------------------------------------------------------
    // Link side: command and data shifting
    // ------------------------------------------------------------------

    // Sample edges shift the serial input in MSB first; the frame counter
    // stops at sixteen so stray extra edges change nothing.
    always_comb begin
        next_lk = lk;
        next_xf = xf;
        if (lk.cnt < FRAME_BITS) begin                     // see RULE23
            next_lk.cnt   = lk.cnt + 5'h01;                 // see RULE8
            next_lk.shift = {lk.shift[6:0], serial_data_in}; // see RULE14
        end
        // Seventh bit: the address is complete and extended by the page.
        if (lk.cnt == CMD_ADDR_BITS - 5'h01) begin          // see RULE10
            next_lk.ext = {sys.page, lk.shift[5:0], serial_data_in};
        end
        // Eighth bit: direction, meaning flipped by the polarity bit.
        if (lk.cnt == CMD_BITS - 5'h01) begin               // see RULE9
            next_lk.is_read = serial_data_in ^ sys.cfg.dir_pol; // see RULE11
            next_lk.hit     = rd_hit;                       // see RULE6
        end
        // Sixteenth bit: the frame is whole, pass it to the system side.
        if (lk.cnt == FRAME_BITS - 5'h01) begin
            next_xf.tog         = ~xf.tog;
            next_xf.frame.write = ~lk.is_read;              // see RULE12
            next_xf.frame.addr  = lk.ext;
            next_xf.frame.data  = {lk.shift[6:0], serial_data_in};
        end
    end

    always_ff @(posedge sample_clk or posedge link_rst) begin
        if (link_rst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // The hand-over word is reset only by the system reset, so the frame
    // it carries is still there when the synchroniser reports it.
    always_ff @(posedge sample_clk or posedge rst) begin
        if (rst) begin
            xf <= '0;
        end else begin
            xf <= next_xf;
        end
    end

    // ------------------------------------------------------------------
    // Link side: read data output
    // ------------------------------------------------------------------

    // The output edge after the eighth sample loads the addressed byte,
    // the next seven shift it MSB first, and the one after the sixteenth
    // sample lets go. Reads of foreign or unsupported addresses never
    // drive, so a companion part on the same wires can answer them.
    always_comb begin
        next_so = so;
        if (lk.cnt == CMD_BITS) begin
            if (lk.is_read && lk.hit) begin                 // see RULE22
                next_so.data  = rd_data;                    // see RULE13
                next_so.drive = 1'b1;                       // see RULE17
            end
        end else if (lk.cnt == FRAME_BITS) begin
            next_so.drive = 1'b0;                           // see RULE17
        end else if (so.drive) begin
            next_so.data = {so.data[6:0], 1'b0};            // see RULE14
        end
    end

    always_ff @(negedge sample_clk or posedge link_rst) begin
        if (link_rst) begin
            so <= '0;
        end else begin
            so <= next_so;
        end
    end

    assign serial_data_out    = so.data[7];
    assign serial_data_out_en = so.drive;

    // ------------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------------

    // Only the toggle crosses through flip-flops. The frame word and the
    // read path are held still while the toggle settles; a read issued
    // right after a write of the same byte at full rate may see old data.
    fwrp_sync #(
        .W (1)
    ) u_frame_sync (
        .clock (clock),
        .rst   (rst),
        .d     (xf.tog),
        .q     (tog_sync)
    );

    assign frame_event   = tog_sync ^ sys.prev_tog;
    assign page_ctrl_hit = xf.frame.addr[ADDR_W-1:0] == PAGE_CTRL_ADDR;

    // Byte storage for the device's own ranges.
    always_comb begin
        store_wr.valid = frame_event & xf.frame.write;
        store_wr.addr  = xf.frame.addr;
        store_wr.data  = xf.frame.data;
    end

    fwrp_reg_store u_store (
        .clock   (clock),
        .rst     (rst),
        .wr      (store_wr),
        .wr_hit  (store_wr_hit),
        .rd_addr (lk.ext),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    // ------------------------------------------------------------------
    // System side: page, configuration and write report
    // ------------------------------------------------------------------

    // Page control answers at address zero of every page. With the return
    // bit set, the chosen page serves one further frame and then page 0
    // comes back, so a single access can reach another page cheaply.
    always_comb begin
        next_sys          = sys;
        next_sys.prev_tog = tog_sync;
        next_sys.wr       = '0;
        if (frame_event) begin
            if (xf.frame.write && page_ctrl_hit) begin
                next_sys.page = xf.frame.data[PAGE_LSB +: PAGE_W]; // see RULE3
                next_sys.ret  = xf.frame.data[RETURN_BIT];
            end else if (sys.ret) begin
                next_sys.page = PAGE_RESET;                 // see RULE3
            end
            if (xf.frame.write && xf.frame.addr == CFG_ADDR) begin
                next_sys.cfg = xf.frame.data[CFG_LSB +: 4]; // see RULE7
            end
            if (xf.frame.write && xf.frame.addr == AUX_ADDR) begin
                next_sys.aux = xf.frame.data;               // see RULE7
            end
            // Report every write that the device itself takes.
            if (xf.frame.write && (page_ctrl_hit || store_wr_hit
                    || xf.frame.addr == CFG_ADDR
                    || xf.frame.addr == AUX_ADDR)) begin
                next_sys.wr.valid = 1'b1;
                next_sys.wr.addr  = xf.frame.addr;
                next_sys.wr.data  = xf.frame.data;
            end
        end
    end

    // The page starts as page 0 so 0x50 to 0x67 are reachable at once.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys.prev_tog <= 1'b0;
            sys.page     <= PAGE_DEFAULT;                   // see RULE4
            sys.ret      <= 1'b0;
            sys.cfg      <= CFG_DEFAULT;
            sys.aux      <= AUX_DEFAULT;
            sys.wr       <= '0;
        end else begin
            sys <= next_sys;
        end
    end

    // Status outputs straight from the system registers; the page is two
    // bits wide because the map holds four pages.
    assign active_page           = sys.page;                // see RULE2
    assign auto_page_zero_return = sys.ret;
    assign link_config           = sys.cfg;
    assign aux_config            = sys.aux;
    assign reg_write             = sys.wr;
endmodule
`default_nettype wire

// file: fwrp_port_asserts.sv
// Concurrent checks on the serial register port's outputs.
`timescale 1ns/10ps
`default_nettype none
module fwrp_port_asserts (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rst,
    // Pins and status
    input wire logic                  select_line,
    input wire logic                  serial_data_out_en,
    input wire fwrp_pkg::fwrp_cfg_s   link_config,
    input wire logic [1:0]            active_page,
    input wire logic                  auto_page_zero_return,
    input wire logic [7:0]            aux_config,
    input wire fwrp_pkg::fwrp_write_s reg_write
);
    import fwrp_pkg::*;
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [8:0] wa;
    logic       wr_legal;
    // Page control, the two config bytes or a writable range.
    assign wa       = reg_write.addr;
    assign wr_legal = wa[6:0] == 7'h00 || wa == CFG_ADDR
                   || wa == AUX_ADDR
                   || (wa >= RANGE_A_LO && wa <= RANGE_A_HI)
                   || (wa >= RANGE_B_LO && wa <= RANGE_B_HI)
                   || (wa >= RANGE_C_LO && wa <= RANGE_C_HI);
    // Select idle on two edges while the configuration holds.
    sequence s_sel_idle;
        (select_line != link_config.sel_pol && $stable(link_config)) [*2];
    endsequence
    // A write pulse carrying a page control byte.
    sequence s_page_wr;
        reg_write.valid && reg_write.addr[6:0] == PAGE_CTRL_ADDR;
    endsequence
    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    chk_pulse_single: assert property (reg_write.valid |=> !reg_write.valid)
        else $error("write pulse longer than one cycle");
    chk_write_range: assert property (reg_write.valid |-> wr_legal)
        else $error("write pulse outside writable map");
    chk_out_idle: assert property (s_sel_idle |-> !serial_data_out_en)
        else $error("output driven with select idle");
    chk_page_write: assert property (s_page_wr |-> active_page == reg_write.data[1:0] && auto_page_zero_return == reg_write.data[7])
        else $error("page control not applied");
    chk_cfg_write: assert property (reg_write.valid && reg_write.addr == CFG_ADDR |-> link_config == reg_write.data[3:0])
        else $error("link config not applied");
    chk_aux_write: assert property (reg_write.valid && reg_write.addr == AUX_ADDR |-> aux_config == reg_write.data)
        else $error("aux config not applied");
    chk_page_cause: assert property ($changed(active_page) |-> (reg_write.valid && reg_write.addr[6:0] == 7'h00) || ($past(auto_page_zero_return) && active_page == 2'h0))
        else $error("page changed without cause");
    chk_cfg_cause: assert property ($changed(link_config) |-> reg_write.valid && reg_write.addr == CFG_ADDR)
        else $error("link config changed without write");
    chk_en_select: assert property ($rose(serial_data_out_en) |-> select_line == link_config.sel_pol)
        else $error("output enabled with select inactive");
endmodule
bind fwrp_port fwrp_port_asserts u_fwrp_port_asserts (
    .clock(clock), .rst(rst), .select_line(select_line),
    .serial_data_out_en(serial_data_out_en), .link_config(link_config),
    .active_page(active_page), .auto_page_zero_return(auto_page_zero_return),
    .aux_config(aux_config), .reg_write(reg_write));
`default_nettype wire

// file: fwrp_host_model.sv
// Host bus master model that drives frames into the serial port.
`timescale 1ns/10ps
`default_nettype none
module fwrp_host_model (
    // System clock, paces frames only
    input  wire logic clock,
    // Device output pins
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_en,
    // Host-driven pins
    output logic      select_line,
    output logic      serial_clock_in,
    output logic      serial_data_in
);
    import fwrp_pkg::*;
    fwrp_cfg_s mode = CFG_RESET;
    // Pins start idle for the reset mode.
    initial begin
        select_line     = 1'b1;
        serial_clock_in = 1'b0;
        serial_data_in  = 1'b0;
    end
    // Park the pins for a new mode; the clock rests at its polarity.
    task set_mode(input fwrp_cfg_s m);
        @(negedge clock);
        mode            = m;
        select_line     = ~m.sel_pol;
        serial_clock_in = m.cpol;
    endtask
    // Data leads each sample edge by 3 ns; released, it toggles.
    task frame(input logic [15:0] bits, input int n,
               output logic [7:0] rd, output logic drove);
        logic rdf;
        logic seen;
        int   i;
        int   e;
        rdf   = bits[8] ^ mode.dir_pol;
        rd    = 8'h00;
        drove = 1'b0;
        seen  = 1'b0;
        @(negedge clock);
        select_line = mode.sel_pol;
        #1.7;
        for (i = 0; i < n; i++) begin
            for (e = 0; e < 2; e++) begin
                if (e == int'(mode.cpha))
                    serial_data_in = (i < 8 || (i < 16 && !rdf)) ?
                        bits[15-i] : ~serial_data_in;
                #3 serial_clock_in = ~serial_clock_in;
                if (e == int'(mode.cpha) && i >= 8 && i < 16) begin
                    seen  = serial_data_out_en ? serial_data_out : ~seen;
                    drove = drove | serial_data_out_en;
                    rd    = {rd[6:0], seen};
                end
            end
        end
        #3;
        @(negedge clock);
        select_line = ~mode.sel_pol;
        repeat (8) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// file: fwrp_port_tb.sv
// Self-checking bench for the four-wire register port.
`timescale 1ns/10ps
`default_nettype none
module fwrp_port_tb;
    import fwrp_pkg::*;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic        sel;
    logic        sck;
    logic        sdi;
    logic        sdo;
    logic        sdo_en;
    fwrp_cfg_s   cfg;
    logic [1:0]  page;
    logic        auto_ret;
    logic [7:0]  aux;
    fwrp_write_s wr;
    fwrp_write_s last_wr;
    int          wr_cnt     = 0;
    int          num_errors = 0;
    int          cmp_count  = 0;
    logic [7:0]  rdv;
    logic        drv;
    int          m;
    // System clock.
    always #5 clock = ~clock;
    fwrp_port u_fwrp_port (.clock(clock), .rst(rst), .select_line(sel),
        .serial_clock_in(sck), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_out_en(sdo_en),
        .link_config(cfg), .active_page(page),
        .auto_page_zero_return(auto_ret), .aux_config(aux),
        .reg_write(wr));
    fwrp_host_model u_fwrp_host_model (.clock(clock),
        .serial_data_out(sdo), .serial_data_out_en(sdo_en),
        .select_line(sel), .serial_clock_in(sck), .serial_data_in(sdi));
    // Log every write pulse the port emits.
    always @(posedge clock) begin
        if (wr.valid === 1'b1) begin
            last_wr <= wr;
            wr_cnt  <= wr_cnt + 1;
        end
    end
    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task cmp(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task finish_test;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Write frame; a dropped write counts zero pulses.
    task wr_chk(input logic [6:0] a, input logic [7:0] d, input int n,
                input logic hit, input logic [8:0] ea);
        int c;
        c = wr_cnt;
        u_fwrp_host_model.frame({a, u_fwrp_host_model.mode.dir_pol, d},
                                n, rdv, drv);
        cmp(18'(wr_cnt - c), 18'(hit));
        if (hit) cmp(last_wr, {1'b1, ea, d});
        cmp(18'(drv), 18'h0);
    endtask
    // Read frame; the enable must drop after it.
    task rd_chk(input logic [6:0] a, input logic [7:0] e, input logic dv);
        u_fwrp_host_model.frame({a, ~u_fwrp_host_model.mode.dir_pol,
                                 8'h00}, 16, rdv, drv);
        cmp(18'(drv), 18'(dv));
        if (dv) cmp(18'(rdv), 18'(e));
        cmp(18'(sdo_en), 18'h0);
    endtask
    // -------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        cmp(18'(page), 18'(PAGE_RESET));
        cmp(18'(cfg), 18'(CFG_RESET));
        cmp(18'(aux), 18'(AUX_RESET));
        wr_chk(7'h50, 8'ha5, 16, 1'b1, 9'h050);
        wr_chk(7'h51, 8'h3c, 16, 1'b1, 9'h051);
        rd_chk(7'h50, 8'ha5, 1'b1);
        rd_chk(7'h51, 8'h3c, 1'b1);
        rd_chk(7'h10, 8'h00, 1'b0);
        wr_chk(7'h10, 8'h77, 16, 1'b0, 9'h000);
        wr_chk(7'h52, 8'h96, 20, 1'b1, 9'h052);
        wr_chk(7'h52, 8'h11, 12, 1'b0, 9'h000);
        rd_chk(7'h52, 8'h96, 1'b1);
        wr_chk(7'h00, 8'h02, 16, 1'b1, 9'h000);
        cmp(18'(page), 18'h2);
        rd_chk(7'h00, 8'h00, 1'b0);
        wr_chk(7'h06, 8'h5a, 16, 1'b1, 9'h106);
        cmp(18'(aux), 18'h5a);
        wr_chk(7'h40, 8'hc3, 16, 1'b1, 9'h140);
        // All sixteen link settings.
        for (m = 0; m < 16; m++) begin
            wr_chk(7'h05, {4'h0, 4'(m)}, 16, 1'b1, 9'h105);
            cmp(18'(cfg), 18'(m));
            u_fwrp_host_model.set_mode(fwrp_cfg_s'(4'(m)));
            wr_chk(7'h41, 8'(m * 17), 16, 1'b1, 9'h141);
            rd_chk(7'h40, 8'hc3, 1'b1);
            rd_chk(7'h41, 8'(m * 17), 1'b1);
        end
        wr_chk(7'h00, 8'h81, 16, 1'b1, 9'h100);
        cmp({15'h0, auto_ret, page}, 18'h5);
        rd_chk(7'h5f, 8'h00, 1'b1);
        cmp(18'(page), 18'h0);
        rd_chk(7'h50, 8'ha5, 1'b1);
        finish_test;
    end
    // Watchdog far beyond the expected run.
    initial begin
        #200000;
        num_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
